/* hw/pss_cfg.svh */
// constants for the program counter and return stack sequencer
// Summary of operation
// - input clock divided by four into four one-hot phase pulses
// - program counter steps in phase 1, fetched word latched in phase 4
// - fetch overlaps execute, one plain instruction per instruction cycle
// - execute over phases 2-4, operand read phase 2, write phase 4
// - program counter changes cost two cycles, prefetched word discarded
// - eight-bit ALU adds, subtracts, shifts, logic ops, two's complement
// - accumulator is eight bits and has no data memory address
// - ALU updates borrow_out, nibble_borrow and result_null flags
// - subtraction flags mean no-borrow rather than carry
// - program counter 13 bits, only low byte reachable
// - low-byte writes and computed jumps take bits 12..8 from pc_high_latch
// - jump and call carry 11 bits, page from latch bits 4 and 3
// - latch page bits do not reach the program memory address
// - program memory space is 1K words, 10-bit fetch address
// - eight by 13-bit return stack, pointer hidden from software
// - call or interrupt pushes full counter, returns pop it
// - push and pop leave pc_high_latch unchanged
// - ninth push overwrites the first, circular
// - ninth pop yields the value of the first pop
// - no overflow or underflow indication, wrap is silent
`ifndef PSS_CFG_SVH
`define PSS_CFG_SVH
`define PSS_PC_W      13
`define PSS_IW        14
`define PSS_PMEM_AW   10
`define PSS_STK_D     8
`define PSS_STK_PW    3
`define PSS_PC_RST    13'h0000
`define PSS_LATCH_RST 5'h00
`define PSS_CTRL_RST  2'h1
`define PSS_IVEC      13'h0010
`define PSS_PAGE_HI   4
`define PSS_PAGE_LO   3
`define PSS_TGT_HI    10
`define PSS_OP_HI     13
`define PSS_OP_LO     11
`define PSS_FN_HI     10
`define PSS_FN_LO     8
`define PSS_OP_ALU    3'h0
`define PSS_OP_NOP    3'h1
`define PSS_OP_PCW    3'h2
`define PSS_OP_IEXIT  3'h3
`define PSS_OP_JMP    3'h4
`define PSS_OP_CALL   3'h5
`define PSS_OP_RET    3'h6
`define PSS_OP_RETL   3'h7
`define PSS_FN_MOV    3'h0
`define PSS_FN_ADD    3'h1
`define PSS_FN_SUB    3'h2
`define PSS_FN_AND    3'h3
`define PSS_FN_IOR    3'h4
`define PSS_FN_XOR    3'h5
`define PSS_FN_RLC    3'h6
`define PSS_FN_RRC    3'h7
`define PSS_A_PCL     3'h0
`define PSS_A_LATH    3'h1
`define PSS_A_CTRL    3'h2
`define PSS_A_STAT    3'h3
`define PSS_C_RUN     0
`define PSS_C_IEN     1
`define PSS_S_BOR     0
`define PSS_S_NIB     1
`define PSS_S_NUL     2
`define PSS_S_IRV     3
`define PSS_S_IRQ     4
`endif

/* hw/pss_pkg.sv */
// types shared by the sequencer modules
`include "pss_cfg.svh"
package pss_pkg;
  typedef enum logic [1:0] {PSS_Q1, PSS_Q2, PSS_Q3, PSS_Q4} pss_qstate_t;
  typedef struct packed {
    logic q1;
    logic q2;
    logic q3;
    logic q4;
  } pss_phase_t;
  typedef struct packed {
    logic                 push;
    logic                 pop;
    logic [`PSS_PC_W-1:0] data;
  } pss_stk_req_t;
  typedef struct packed {
    logic borrow_out;
    logic nibble_borrow;
    logic result_null;
  } pss_flags_t;
endpackage : pss_pkg

/* hw/pss_qdiv.sv */
// four-phase divider producing one-cycle phase enables
`timescale 1ns/1ns
`default_nettype none
module pss_qdiv
  import pss_pkg::*;
(
  input  wire logic       mclk_in,
  input  wire logic       rst_n_in,
  input  wire logic       run_in,
  output var  pss_phase_t phase_out
);
  pss_qstate_t q_reg;

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      q_reg <= PSS_Q1;
    end else if (run_in) begin
      case (q_reg)
        PSS_Q1:  q_reg <= PSS_Q2;
        PSS_Q2:  q_reg <= PSS_Q3;
        PSS_Q3:  q_reg <= PSS_Q4;
        default: q_reg <= PSS_Q1;
      endcase
    end
  end

  // halted divider holds its place so a restart resumes mid-cycle
  always_comb begin
    phase_out.q1 = run_in && (q_reg == PSS_Q1);
    phase_out.q2 = run_in && (q_reg == PSS_Q2);
    phase_out.q3 = run_in && (q_reg == PSS_Q3);
    phase_out.q4 = run_in && (q_reg == PSS_Q4);
  end

  sequence s_q1_run;
    phase_out.q1 ##1 run_in;
  endsequence

  a_phase_order: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    s_q1_run |-> phase_out.q2 ##1 (!run_in || phase_out.q3))
    else $error("phase 2 did not follow phase 1");

  a_phase_single: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    $onehot0(phase_out))
    else $error("phases overlap");

  a_phase_wrap: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    phase_out.q4 ##1 run_in |-> phase_out.q1)
    else $error("phase 1 did not follow phase 4");
endmodule : pss_qdiv
`default_nettype wire

/* hw/pss_rstk.sv */
// eight-deep circular return address stack
`timescale 1ns/1ns
`default_nettype none
module pss_rstk
  import pss_pkg::*;
(
  input  wire logic                 mclk_in,
  input  wire logic                 rst_n_in,
  input  wire pss_stk_req_t         req_in,
  output var  logic [`PSS_PC_W-1:0] top_out
);
  logic [`PSS_PC_W-1:0]   mem_reg [`PSS_STK_D];
  logic [`PSS_STK_PW-1:0] ptr_reg;
  logic [`PSS_STK_PW-1:0] ptr_dn;

  // 3-bit pointer wraps by itself; no overflow flag exists at all
  assign ptr_dn  = ptr_reg - `PSS_STK_PW'(1);
  assign top_out = mem_reg[ptr_dn];

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      ptr_reg <= '0;
    end else if (req_in.push) begin
      ptr_reg <= ptr_reg + `PSS_STK_PW'(1);
    end else if (req_in.pop) begin
      ptr_reg <= ptr_dn;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (req_in.push) begin
      mem_reg[ptr_reg] <= req_in.data;
    end
  end

  a_push_wrap: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    req_in.push |=> ptr_reg == $past(ptr_reg) + `PSS_STK_PW'(1))
    else $error("push did not advance pointer");

  a_pop_wrap: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    req_in.pop && !req_in.push |=> ptr_reg == $past(ptr_dn))
    else $error("pop did not retreat pointer");

  a_push_top: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    req_in.push |=> top_out == $past(req_in.data))
    else $error("pushed value not on top");
endmodule : pss_rstk
`default_nettype wire

/* hw/pss_core.sv */
// instruction sequencer core with wishbone register slave
`timescale 1ns/1ns
`default_nettype none
module pss_core
  import pss_pkg::*;
(
  input  wire logic                   mclk_in,
  input  wire logic                   rst_n_in,
  input  wire logic                   wb_cyc_in,
  input  wire logic                   wb_stb_in,
  input  wire logic                   wb_we_in,
  input  wire logic [7:0]             wb_adr_in,
  input  wire logic [3:0]             wb_sel_in,
  input  wire logic [31:0]            wb_dat_in,
  output var  logic [31:0]            wb_dat_out,
  output var  logic                   wb_ack_out,
  output var  logic [`PSS_PMEM_AW-1:0] pmem_addr_out,
  input  wire logic [`PSS_IW-1:0]     pmem_data_in,
  input  wire logic                   irq_in,
  output var  pss_phase_t             phase_out
);
  logic [`PSS_PC_W-1:0] pc_reg;
  logic [`PSS_PC_W-1:0] fetch_addr_reg;
  logic [`PSS_IW-1:0]   ir_reg;
  logic                 ir_valid_reg;
  logic [7:0]           acc_reg;
  logic [7:0]           operand_reg;
  pss_flags_t           flags_reg;
  pss_flags_t           flags_next;
  logic [4:0]           latch_reg;
  logic [1:0]           ctrl_reg;
  logic [2:0]           irq_sync_reg;
  logic                 irq_level_reg;
  logic                 ack_reg;
  logic [31:0]          dat_reg;
  logic [`PSS_PC_W-1:0] stk_top;
  pss_stk_req_t         stk_req;
  pss_phase_t           ph;

  function automatic logic [`PSS_PC_W-1:0] page_target(
    input logic [4:0]  lath,
    input logic [`PSS_TGT_HI:0] lit
  );
    page_target = {lath[`PSS_PAGE_HI:`PSS_PAGE_LO], lit};
  endfunction : page_target

  function automatic logic is_op(
    input logic [`PSS_IW-1:0] word,
    input logic [2:0]         code
  );
    is_op = (word[`PSS_OP_HI:`PSS_OP_LO] == code);
  endfunction : is_op

  pss_qdiv u_qdiv (
    .mclk_in   (mclk_in),
    .rst_n_in  (rst_n_in),
    .run_in    (ctrl_reg[`PSS_C_RUN]),
    .phase_out (ph)
  );

  pss_rstk u_rstk (
    .mclk_in  (mclk_in),
    .rst_n_in (rst_n_in),
    .req_in   (stk_req),
    .top_out  (stk_top)
  );

  assign phase_out = ph;

  // ---- decode of the instruction under execution
  logic       exec_ok;
  logic       is_jmp;
  logic       is_call;
  logic       is_pcw;
  logic       is_iexit;
  logic       is_retl;
  logic       is_ret_any;
  logic       is_alu;
  logic       branch;
  logic [2:0] alu_fn;
  logic [7:0] ir_lit;

  assign exec_ok    = ir_valid_reg;
  assign is_jmp     = exec_ok && is_op(ir_reg, `PSS_OP_JMP);
  assign is_call    = exec_ok && is_op(ir_reg, `PSS_OP_CALL);
  assign is_pcw     = exec_ok && is_op(ir_reg, `PSS_OP_PCW);
  assign is_iexit   = exec_ok && is_op(ir_reg, `PSS_OP_IEXIT);
  assign is_retl    = exec_ok && is_op(ir_reg, `PSS_OP_RETL);
  assign is_ret_any = is_iexit || is_retl ||
                      (exec_ok && is_op(ir_reg, `PSS_OP_RET));
  assign is_alu     = exec_ok && is_op(ir_reg, `PSS_OP_ALU);
  assign branch     = is_jmp || is_call || is_pcw || is_ret_any;
  assign alu_fn     = ir_reg[`PSS_FN_HI:`PSS_FN_LO];
  assign ir_lit     = ir_reg[7:0];

  // ---- wishbone slave; accesses land on phase 4 so they never tear
  // an instruction in flight, or at once while the core is halted
  logic       bus_slot;
  logic       bus_take;
  logic       bus_wr;
  logic [2:0] reg_idx;
  logic       mapped;
  logic       bus_pcl_wr;
  logic       bus_lath_wr;
  logic       bus_ctrl_wr;
  logic       int_take;

  assign bus_slot    = ph.q4 || !ctrl_reg[`PSS_C_RUN];
  assign bus_take    = wb_cyc_in && wb_stb_in && !ack_reg && bus_slot;
  assign reg_idx     = wb_adr_in[4:2];
  assign mapped      = (wb_adr_in[7:5] == 3'h0) && (reg_idx <= `PSS_A_STAT);
  assign bus_wr      = bus_take && wb_we_in && wb_sel_in[0] && mapped;
  assign bus_pcl_wr  = bus_wr && (reg_idx == `PSS_A_PCL);
  assign bus_lath_wr = bus_wr && (reg_idx == `PSS_A_LATH);
  assign bus_ctrl_wr = bus_wr && (reg_idx == `PSS_A_CTRL);

  // an interrupt waits out a branch so the return address stays exact
  assign int_take = ph.q4 && irq_level_reg && ctrl_reg[`PSS_C_IEN] &&
                    !branch && !bus_pcl_wr;

  function automatic logic [31:0] reg_read(input logic [2:0] idx);
    reg_read = 32'h0000_0000;
    case (idx)
      `PSS_A_PCL:  reg_read[7:0] = pc_reg[7:0];
      `PSS_A_LATH: reg_read[4:0] = latch_reg;
      `PSS_A_CTRL: reg_read[1:0] = ctrl_reg;
      `PSS_A_STAT: begin
        reg_read[`PSS_S_BOR] = flags_reg.borrow_out;
        reg_read[`PSS_S_NIB] = flags_reg.nibble_borrow;
        reg_read[`PSS_S_NUL] = flags_reg.result_null;
        reg_read[`PSS_S_IRV] = ir_valid_reg;
        reg_read[`PSS_S_IRQ] = irq_level_reg;
      end
      default: reg_read = 32'h0000_0000;
    endcase
  endfunction : reg_read

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_take;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      dat_reg <= 32'h0000_0000;
    end else if (bus_take && !wb_we_in) begin
      dat_reg <= mapped ? reg_read(reg_idx) : 32'h0000_0000;
    end
  end

  assign wb_ack_out = ack_reg;
  assign wb_dat_out = dat_reg;

  // ---- latch and control; the stack never touches the latch
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      latch_reg <= `PSS_LATCH_RST;
    end else if (bus_lath_wr) begin
      latch_reg <= wb_dat_in[4:0];
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      ctrl_reg <= `PSS_CTRL_RST;
    end else begin
      if (bus_ctrl_wr) begin
        ctrl_reg <= wb_dat_in[1:0];
      end
      if (int_take) begin
        ctrl_reg[`PSS_C_IEN] <= 1'b0;
      end
      // hardware set beats a software clear in the same cycle
      if (ph.q4 && is_iexit && !bus_pcl_wr) begin
        ctrl_reg[`PSS_C_IEN] <= 1'b1;
      end
    end
  end

  // ---- interrupt pin, three stages, level moves when 2 and 3 agree
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      irq_sync_reg  <= 3'h0;
      irq_level_reg <= 1'b0;
    end else begin
      irq_sync_reg <= {irq_sync_reg[1:0], irq_in};
      if (irq_sync_reg[1] == irq_sync_reg[2]) begin
        irq_level_reg <= irq_sync_reg[2];
      end
    end
  end

  // ---- program counter and fetch address
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      pc_reg         <= `PSS_PC_RST;
      fetch_addr_reg <= `PSS_PC_RST;
    end else if (bus_pcl_wr) begin
      pc_reg <= {latch_reg, wb_dat_in[7:0]};
    end else if (ph.q1) begin
      fetch_addr_reg <= pc_reg;
      pc_reg         <= pc_reg + `PSS_PC_W'(1);
    end else if (ph.q4) begin
      if (is_jmp || is_call) begin
        pc_reg <= page_target(latch_reg, ir_reg[`PSS_TGT_HI:0]);
      end else if (is_pcw) begin
        pc_reg <= {latch_reg, acc_reg};
      end else if (is_ret_any) begin
        pc_reg <= stk_top;
      end else if (int_take) begin
        pc_reg <= `PSS_IVEC;
      end
    end
  end

  // page bits above the implemented space are dropped here
  assign pmem_addr_out = fetch_addr_reg[`PSS_PMEM_AW-1:0];

  // ---- stack requests; return address is the word being discarded
  always_comb begin
    stk_req.push = ph.q4 && !bus_pcl_wr && (is_call || int_take);
    stk_req.pop  = ph.q4 && !bus_pcl_wr && is_ret_any;
    stk_req.data = fetch_addr_reg;
  end

  // ---- instruction register, flushed on any counter change
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      ir_reg       <= '0;
      ir_valid_reg <= 1'b0;
    end else if (bus_pcl_wr) begin
      ir_valid_reg <= 1'b0;
      if (ph.q4) begin
        ir_reg <= pmem_data_in;
      end
    end else if (ph.q4) begin
      ir_reg       <= pmem_data_in;
      ir_valid_reg <= !(branch || int_take);
    end
  end

  // ---- ALU, operand taken in phase 2 and result written in phase 4
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      operand_reg <= 8'h00;
    end else if (ph.q2) begin
      operand_reg <= acc_reg;
    end
  end

  logic [7:0] alu_res;
  logic [8:0] sum9;
  logic [4:0] nib5;
  logic       upd_c;
  logic       upd_z;

  always_comb begin
    sum9       = 9'h000;
    nib5       = 5'h00;
    alu_res    = operand_reg;
    upd_c      = 1'b0;
    upd_z      = 1'b1;
    flags_next = flags_reg;
    case (alu_fn)
      `PSS_FN_MOV: alu_res = ir_lit;
      `PSS_FN_ADD: begin
        sum9    = {1'b0, ir_lit} + {1'b0, operand_reg};
        nib5    = {1'b0, ir_lit[3:0]} + {1'b0, operand_reg[3:0]};
        alu_res = sum9[7:0];
        upd_c   = 1'b1;
      end
      `PSS_FN_SUB: begin
        // two's complement add of the inverse: carry out means no borrow
        sum9    = {1'b0, ir_lit} + {1'b0, ~operand_reg} + 9'h001;
        nib5    = {1'b0, ir_lit[3:0]} + {1'b0, ~operand_reg[3:0]} + 5'h01;
        alu_res = sum9[7:0];
        upd_c   = 1'b1;
      end
      `PSS_FN_AND: alu_res = ir_lit & operand_reg;
      `PSS_FN_IOR: alu_res = ir_lit | operand_reg;
      `PSS_FN_XOR: alu_res = ir_lit ^ operand_reg;
      `PSS_FN_RLC: begin
        alu_res = {operand_reg[6:0], flags_reg.borrow_out};
        sum9[8] = operand_reg[7];
        upd_z   = 1'b0;
      end
      default: begin
        alu_res = {flags_reg.borrow_out, operand_reg[7:1]};
        sum9[8] = operand_reg[0];
        upd_z   = 1'b0;
      end
    endcase
    if (upd_c || !upd_z) begin
      flags_next.borrow_out = sum9[8];
    end
    if (upd_c) begin
      flags_next.nibble_borrow = nib5[4];
    end
    if (upd_z) begin
      flags_next.result_null = (alu_res == 8'h00);
    end
  end

  // accumulator lives only here, never in the data map
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      acc_reg   <= 8'h00;
      flags_reg <= '0;
    end else if (ph.q4 && is_alu) begin
      acc_reg   <= alu_res;
      flags_reg <= flags_next;
    end else if (ph.q4 && is_retl && !bus_pcl_wr) begin
      acc_reg <= ir_lit;
    end
  end

  // ---- checks
  sequence s_branch_q4;
    ph.q4 && branch && !bus_pcl_wr;
  endsequence

  sequence s_plain_q4;
    ph.q4 && !branch && !int_take && !bus_pcl_wr;
  endsequence

  a_pc_step: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    ph.q1 && !bus_pcl_wr |=> pc_reg == $past(pc_reg) + `PSS_PC_W'(1))
    else $error("counter did not step in phase 1");

  a_ir_latch: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    ph.q4 |=> ir_reg == $past(pmem_data_in))
    else $error("fetched word not latched in phase 4");

  a_branch_flush: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    s_branch_q4 |=> !ir_valid_reg [*3])
    else $error("branch did not discard prefetched word");

  a_plain_rate: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    s_plain_q4 |=> ir_valid_reg [*4])
    else $error("plain instruction stalled the pipeline");

  a_jump_page: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    ph.q4 && is_jmp && !bus_pcl_wr |=>
      pc_reg == {$past(latch_reg[4:3]), $past(ir_reg[10:0])})
    else $error("jump target page wrong");

  a_pcl_load: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    bus_pcl_wr |=> pc_reg[12:8] == $past(latch_reg))
    else $error("low byte write did not load high bits from latch");

  a_sub_borrow: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    ph.q4 && is_alu && alu_fn == `PSS_FN_SUB |=>
      flags_reg.borrow_out == ($past(ir_lit) >= $past(operand_reg)))
    else $error("subtract borrow flag wrong");

  a_latch_keep: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (stk_req.push || stk_req.pop) && !bus_lath_wr |=> $stable(latch_reg))
    else $error("stack operation changed latch");

  a_acc_q4: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    !ph.q4 |=> $stable(acc_reg))
    else $error("accumulator written outside phase 4");

  a_call_return: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    ph.q4 && is_call && !bus_pcl_wr |=> stk_top == $past(fetch_addr_reg))
    else $error("call did not push return address");
endmodule : pss_core
`default_nettype wire

/* verification/pss_pmem_model.sv */
// program memory model answering fetch addresses
`timescale 1ns/1ns
`default_nettype none
module pss_pmem_model
  import pss_pkg::*;
(
  input  wire logic [9:0]  addr_in,
  output var  logic [13:0] data_out
);
  logic [13:0] mem [0:1023]; // full 1K word space
  // combinational read: word is settled long before the phase-4 sample
  always_comb begin
    data_out = mem[addr_in];
  end
endmodule : pss_pmem_model
`default_nettype wire

/* verification/pss_core_tb.sv */
// self-checking bench for the sequencer core
`timescale 1ns/1ns
`default_nettype none
`include "pss_cfg.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
  bad_count++; $display("FAIL %0t got %h exp %h", $time, g, e); end end
module pss_core_tb;
  import pss_pkg::*;
  logic        mclk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'hF;
  logic        irq = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] wb_q;
  logic        wb_ack;
  logic [9:0]  paddr;
  logic [13:0] pdata;
  pss_phase_t  phase;
  int          bad_count = 0;
  int          checks_done = 0;
  int          cycles = 0;
  int          seed = 59;
  logic [9:0]  got[$];
  logic [9:0]  exp[$];
  logic [31:0] q;

  always #25 mclk_in = ~mclk_in;

  pss_core DUT (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
    .wb_dat_in(wdat), .wb_dat_out(wb_q), .wb_ack_out(wb_ack),
    .pmem_addr_out(paddr), .pmem_data_in(pdata), .irq_in(irq),
    .phase_out(phase));
  pss_pmem_model PM (.addr_in(paddr), .data_out(pdata));

  task automatic end_sim();
    $display("mismatches %0d checks %0d", bad_count, checks_done);
    if (bad_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  // generous ceiling: the whole sequence needs under 2000 cycles
  always @(posedge mclk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      end_sim();
    end
  end

  task automatic reset_dut();
    rst_n_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    rst_n_in <= 1'b1;
  endtask : reset_dut

  task automatic wb(input logic w, input logic [7:0] ad,
                    input logic [31:0] d, output logic [31:0] r);
    @(posedge mclk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    wdat <= d;
    @(posedge mclk_in);
    while (wb_ack !== 1'b1) @(posedge mclk_in);
    r = wb_q;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge mclk_in);
  endtask : wb

  // records each fetch address and the phase rhythm from reset release
  task automatic collect(input int n);
    int   gap;
    logic was;
    got.delete();
    gap = 0;
    #1;
    was = phase.q1;
    `CHK(phase, 4'b1000)
    while (got.size() < n) begin
      @(posedge mclk_in);
      #1;
      gap++;
      if (was) got.push_back(paddr);
      was = phase.q1;
      `CHK($countones(phase), 1)
      if (was) begin
        `CHK(gap, 4)
        gap = 0;
      end
    end
  endtask : collect

  // flags by definition: add carries out, subtract reports no-borrow
  function automatic logic [2:0] flags_exp(input logic [2:0] fn,
                                           input logic [7:0] l,
                                           input logic [7:0] w);
    logic [8:0] s;
    logic [4:0] n;
    s = 9'(l) + 9'(w);
    n = 5'(l[3:0]) + 5'(w[3:0]);
    if (fn == `PSS_FN_ADD) flags_exp = {s[7:0] == 8'h00, n[4], s[8]};
    else flags_exp = {l == w, l[3:0] >= w[3:0], l >= w};
  endfunction : flags_exp

  task automatic test_alu(input int k);
    logic [7:0] a, c, t;
    logic [4:0] lat;
    logic [2:0] fn;
    a = 8'($random(seed));
    c = (k == 0) ? a : 8'($random(seed));
    fn = (k == 2) ? `PSS_FN_ADD : `PSS_FN_SUB;
    t = (k == 2) ? c + a : c - a;
    // avoid landing the jump target's successor on the program itself
    if (t == 8'hFF) begin
      c = c + 8'h01;
      t = 8'h00;
    end
    lat = (5'($random(seed)) & 5'h1C) | 5'h02;
    foreach (PM.mem[i]) PM.mem[i] = 14'h0800;
    PM.mem[2] = {`PSS_OP_JMP, 11'h300};
    PM.mem[10'h300] = {`PSS_OP_ALU, `PSS_FN_MOV, a};
    PM.mem[10'h301] = {`PSS_OP_ALU, fn, c};
    PM.mem[10'h302] = {`PSS_OP_PCW, 11'h000};
    reset_dut();
    fork
      collect(10);
      wb(1'b1, 8'h04, {27'h0, lat}, q);
    join
    exp = '{10'h000, 10'h001, 10'h002, 10'h003, 10'h300, 10'h301,
            10'h302, 10'h303, {2'b10, t}, {2'b10, t} + 10'h001};
    foreach (exp[i]) `CHK(got[i], exp[i])
    wb(1'b0, 8'h0C, 32'h0, q);
    `CHK(q[2:0], flags_exp(fn, c, a))
    wb(1'b0, 8'h04, 32'h0, q);
    `CHK(q[4:0], lat)
    wb(1'b0, 8'h40, 32'h0, q);
    `CHK(q, 32'h0)
  endtask : test_alu

  // nine nested calls then returns: wraps the eight-entry stack
  task automatic test_stack();
    logic [4:0] lat;
    lat = 5'($random(seed));
    foreach (PM.mem[i]) PM.mem[i] = 14'h0800;
    for (int j = 0; j < 9; j++) begin
      PM.mem[16 * j] = {`PSS_OP_CALL, 11'(16 * j + 16)};
      PM.mem[16 * j + 1] = {`PSS_OP_RET, 11'h000};
    end
    PM.mem[10'h090] = {`PSS_OP_RET, 11'h000};
    reset_dut();
    fork
      collect(38);
      wb(1'b1, 8'h04, {27'h0, lat}, q);
    join
    exp.delete();
    for (int j = 0; j < 10; j++) begin
      exp.push_back(10'(16 * j));
      exp.push_back(10'(16 * j + 1));
    end
    for (int j = 8; j > 0; j--) begin
      exp.push_back(10'(16 * j + 1));
      exp.push_back(10'(16 * j + 2));
    end
    exp.push_back(10'h081);
    exp.push_back(10'h082);
    foreach (exp[i]) `CHK(got[i], exp[i])
    wb(1'b0, 8'h04, 32'h0, q);
    `CHK(q[4:0], lat)
  endtask : test_stack

  // interrupt mid-stream: vector, back to the discarded word, enable bit
  task automatic test_irq(input logic [2:0] op);
    logic was;
    foreach (PM.mem[i]) PM.mem[i] = 14'h0800;
    PM.mem[10'(`PSS_IVEC)] = {op, 11'h05A};
    reset_dut();
    wb(1'b1, 8'h08, 32'h3, q);
    repeat ($unsigned($random(seed)) % 8) @(posedge mclk_in);
    irq <= 1'b1;
    got.delete();
    was = 1'b0;
    while (got.size() < 3 ||
           got[got.size() - 3] !== 10'(`PSS_IVEC)) begin
      @(posedge mclk_in);
      if (got.size() > 0 && got[got.size() - 1] === 10'(`PSS_IVEC))
        irq <= 1'b0;
      #1;
      if (was) got.push_back(paddr);
      was = phase.q1;
    end
    `CHK(got[got.size() - 1], got[got.size() - 4])
    wb(1'b0, 8'h08, 32'h0, q);
    `CHK(q[1:0], {op == `PSS_OP_IEXIT, 1'b1})
  endtask : test_irq

  initial begin
    for (int k = 0; k < 3; k++) test_alu(k);
    // second pass uses a new random latch value; the fetch trace does not depend on where the pointer starts
    for (int k = 0; k < 2; k++) test_stack();
    test_irq(`PSS_OP_RETL);
    test_irq(`PSS_OP_IEXIT);
    wb(1'b1, 8'h08, 32'h0, q);
    @(posedge mclk_in);
    #1;
    `CHK(phase, 4'b0000)
    end_sim();
  end
endmodule : pss_core_tb
`default_nettype wire
